// file: core/usb_uart_pin_control.sv
// Pin-level control of the USB serial bridge: UART lines, modem handshakes,
// configurable auxiliary pins, suspend pulls, remote wake, clear, test, clock select.
// Assumes all inputs are synchronous to clk_sys; configuration arrives as plain ports.
//
// Functional notes
// - Ring indicator low for 20 ms while enabled and suspended requests USB resume.
// - Device resets while the active-low external clear input is low.
// - Each auxiliary pin function comes from configuration memory, not fixed hardware.
// - Auxiliary pin 4 is output only outside reset, which releases it; factory default is active-low suspend indicator.
// - Factory pins 0-3: tx LED low, rx LED low, driver enable, power enable low.
// - Optional config makes input-mode pins pull weakly low during USB suspend.
// - Active-low power enable is driven high throughout USB suspend.
// - Device drives data out, DTR, RTS; partner drives the rest; handshakes active low.
// - Optional external 12 MHz oscillator used; internal clock when none is present.
`default_nettype none
module usb_uart_pin_control #(
    parameter int RI_PULSE_CYC = uart_pin_pkg::RI_PULSE_CYC // Wake pulse length
) (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic ext_clear_n, // External clear, active low
    input wire logic test_sel, // Factory test select
    input wire logic osc_in_present, // External oscillator detected on osc_in
    input wire logic cfg_loaded, // Configuration memory contents valid
    input wire logic [uart_pin_pkg::AUX_N-1:0][uart_pin_pkg::AUX_FN_W-1:0] aux_fn_cfg, // Codes
    input wire logic pull_low_in_suspend, // Config option: pull inputs low in suspend
    input wire logic remote_wake_en, // Config option: remote wake enabled
    input wire logic usb_suspend, // USB link suspended
    input wire logic tx_active, // Transmit activity from framer
    input wire logic rx_active, // Receive activity from framer
    input wire logic tx_busy, // Transmit frame in progress
    input wire logic txd_core, // Serial data from framer
    input wire logic dtr_core_n, // DTR request from core, active low
    input wire logic rts_core_n, // RTS request from core, active low
    input wire logic rxd, // Serial data in pin
    input wire logic cts_n, // Clear to send pin
    input wire logic dsr_n, // Data set ready pin
    input wire logic carrier_detect_n, // Carrier detect pin
    input wire logic ring_indicator_n, // Ring indicator pin
    input wire logic [uart_pin_pkg::AUX_N-1:0] aux_pin_i, // Aux pin input levels
    output logic txd_r, // Serial data out pin
    output logic dtr_n_r, // Data terminal ready pin
    output logic rts_n_r, // Request to send pin
    output logic rxd_r, // Registered serial data in
    output logic cts_n_r, // Registered clear to send
    output logic dsr_n_r, // Registered data set ready
    output logic carrier_detect_n_r, // Registered carrier detect
    output logic ring_indicator_n_r, // Registered ring indicator
    output logic [uart_pin_pkg::AUX_N-1:0] aux_pin_o_r, // Aux pin output levels
    output logic [uart_pin_pkg::AUX_N-1:0] aux_pin_oe_n_r, // Aux drive enable, low drives
    output logic [uart_pin_pkg::AUX_N-1:0] aux_pin_in_r, // Registered aux input levels
    output logic [uart_pin_pkg::AUX_N-1:0] aux_pull_dn_r, // Weak pull low, else pull up
    output logic resume_req_r, // Resume request to USB engine
    output logic test_mode_r, // IC test mode entered
    output logic clk_sel_ext_r // Running from external oscillator
);
    import uart_pin_pkg::*;

    logic rst_int;

    // Pick the effective function of one pin
    function automatic logic [3:0] pick_fn(input int idx, input logic loaded,
                                           input logic [3:0] cfg);
        logic [3:0] f;
        f = loaded ? cfg : AUX_DEFAULT[idx];
        if (idx == PIN_OUT_ONLY && (f == FN_IO_IN || f[3])) begin
            f = FN_SLEEP;
        end
        return f;
    endfunction

    // Decode a function into {oe_n, level}
    function automatic logic [1:0] drive(input logic [3:0] f, input logic txa,
                                         input logic rxa, input logic busy,
                                         input logic susp);
        logic [1:0] d;
        case (f)
            FN_TX_ACTIVITY_LED_N: d = {1'b0, !txa};
            FN_RX_ACTIVITY_LED_N: d = {1'b0, !rxa};
            FN_TX_DRIVER_ENABLE: d = {1'b0, busy};
            FN_POWER_ENABLE_N: d = {1'b0, susp};
            FN_SLEEP: d = {1'b0, !susp};
            FN_DRIVE_0: d = {1'b0, 1'b0};
            FN_DRIVE_1: d = {1'b0, 1'b1};
            default: d = {1'b1, 1'b0};
        endcase
        return d;
    endfunction

    // External clear joins the system reset
    assign rst_int = srst || !ext_clear_n;

    // Serial and handshake lines
    logic txd_nxt, dtr_n_nxt, rts_n_nxt;
    logic rxd_nxt, cts_n_nxt, dsr_n_nxt, dcd_n_nxt, ri_n_nxt;
    logic test_nxt, clk_ext_nxt;

    always_comb begin
        txd_nxt = txd_core;
        dtr_n_nxt = dtr_core_n;
        rts_n_nxt = rts_core_n;
        rxd_nxt = rxd;
        cts_n_nxt = cts_n;
        dsr_n_nxt = dsr_n;
        dcd_n_nxt = carrier_detect_n;
        ri_n_nxt = ring_indicator_n;
        test_nxt = test_sel;
        clk_ext_nxt = osc_in_present;
    end

    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            txd_r <= TXD_RST;
            dtr_n_r <= HS_N_RST;
            rts_n_r <= HS_N_RST;
            rxd_r <= 1'b1;
            cts_n_r <= HS_N_RST;
            dsr_n_r <= HS_N_RST;
            carrier_detect_n_r <= HS_N_RST;
            ring_indicator_n_r <= HS_N_RST;
            test_mode_r <= 1'b0;
            clk_sel_ext_r <= 1'b0;
        end else if (ce) begin
            txd_r <= txd_nxt;
            dtr_n_r <= dtr_n_nxt;
            rts_n_r <= rts_n_nxt;
            rxd_r <= rxd_nxt;
            cts_n_r <= cts_n_nxt;
            dsr_n_r <= dsr_n_nxt;
            carrier_detect_n_r <= dcd_n_nxt;
            ring_indicator_n_r <= ri_n_nxt;
            test_mode_r <= test_nxt;
            clk_sel_ext_r <= clk_ext_nxt;
        end
    end

    // Auxiliary pins, one slice each
    logic [AUX_N-1:0] aux_o_nxt, aux_oe_n_nxt, aux_in_nxt, aux_pull_nxt;

    for (genvar i = 0; i < AUX_N; i++) begin : g_aux
        logic [3:0] fn;
        logic [1:0] d;

        always_comb begin
            fn = pick_fn(i, cfg_loaded, aux_fn_cfg[i]);
            d = drive(fn, tx_active, rx_active, tx_busy, usb_suspend);
            aux_oe_n_nxt[i] = d[1];
            aux_o_nxt[i] = d[0];
            aux_in_nxt[i] = aux_pin_i[i];
            aux_pull_nxt[i] = d[1] && usb_suspend && pull_low_in_suspend;
        end

        always_ff @(posedge clk_sys) begin
            if (rst_int) begin
                aux_pin_o_r[i] <= AUX_O_RST[i];
                aux_pin_oe_n_r[i] <= AUX_OE_N_RST[i];
                aux_pin_in_r[i] <= 1'b1;
                aux_pull_dn_r[i] <= AUX_PULL_RST[i];
            end else if (ce) begin
                aux_pin_o_r[i] <= aux_o_nxt[i];
                aux_pin_oe_n_r[i] <= aux_oe_n_nxt[i];
                aux_pin_in_r[i] <= aux_in_nxt[i];
                aux_pull_dn_r[i] <= aux_pull_nxt[i];
            end
        end
    end

    // Remote wake through the ring indicator
    ri_wake_detect #(
        .PULSE_CYC(RI_PULSE_CYC)
    ) u_wake (
        .clk_sys(clk_sys),
        .srst(rst_int),
        .ce(ce),
        .wake_en(remote_wake_en),
        .usb_suspend(usb_suspend),
        .ring_indicator_n(ring_indicator_n),
        .resume_req_r(resume_req_r)
    );

    // Clear input forces reset values on the next edge
    property p_clear;
        @(posedge clk_sys) disable iff (srst)
        !ext_clear_n |=> txd_r && aux_pin_oe_n_r == AUX_OE_N_RST && !resume_req_r
            && !test_mode_r;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset pins");

    // Configured drive-high code on pin 0 takes effect
    property p_cfg_fn;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce && cfg_loaded && aux_fn_cfg[0] == FN_DRIVE_1)
            |=> aux_pin_o_r[0] && !aux_pin_oe_n_r[0];
    endproperty
    a_cfg_fn: assert property (p_cfg_fn) else $error("pin 0 ignored configured function");

    // Pin 4 is driven after every enabled edge outside reset and clear
    property p_out_only;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce) |=> !aux_pin_oe_n_r[PIN_OUT_ONLY];
    endproperty
    a_out_only: assert property (p_out_only) else $error("pin 4 released as input");

    // Factory pins follow activity and suspend
    property p_factory;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce && !cfg_loaded) |=> aux_pin_o_r[0] == !$past(tx_active)
            && aux_pin_o_r[1] == !$past(rx_active) && aux_pin_o_r[2] == $past(tx_busy)
            && aux_pin_o_r[4] == !$past(usb_suspend);
    endproperty
    a_factory: assert property (p_factory) else $error("factory pin mapping wrong");

    // Input-mode pin 0 pulls low only when suspended with the option set
    property p_pull;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce) |=> aux_pull_dn_r[0] == ($past(usb_suspend)
            && $past(pull_low_in_suspend) && $past(cfg_loaded)
            && ($past(aux_fn_cfg[0]) == FN_IO_IN || $past(aux_fn_cfg[0][3])));
    endproperty
    a_pull: assert property (p_pull) else $error("suspend pull wrong");

    // Power enable inactive during suspend
    property p_power_enable_n;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce && !cfg_loaded && usb_suspend) |=> aux_pin_o_r[PIN_POWER_ENABLE_N]
            ##1 ($past(cfg_loaded) || !$past(usb_suspend) || aux_pin_o_r[PIN_POWER_ENABLE_N]);
    endproperty
    a_power_enable_n: assert property (p_power_enable_n) else $error("power enable active in suspend");

    // Serial outputs follow the core, and the ring indicator its pin, one cycle later
    property p_serial;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce) |=> txd_r == $past(txd_core)
            && dtr_n_r == $past(dtr_core_n) && rts_n_r == $past(rts_core_n)
            && ring_indicator_n_r == $past(ring_indicator_n);
    endproperty
    a_serial: assert property (p_serial) else $error("serial lines not passed");

    // Clock source follows oscillator presence
    property p_clk_sel;
        @(posedge clk_sys) disable iff (srst)
        (!srst && ext_clear_n && ce) |=> clk_sel_ext_r == $past(osc_in_present);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock source select wrong");
endmodule
`default_nettype wire

// file: core/uart_pin_pkg.sv
// Shared constants for the serial bridge pin-control block.
// Assumes a single 25 MHz system clock and synchronous inputs.
`default_nettype none
package uart_pin_pkg;
    // Clock and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int RI_PULSE_MS = 20;
    localparam int RI_PULSE_CYC = (RI_PULSE_MS * (CLK_HZ / 1000));
    localparam int RI_CNT_W = 20;

    // Auxiliary pin count and function code width
    localparam int AUX_N = 5;
    localparam int AUX_FN_W = 4;

    // Auxiliary pin function codes held in configuration memory
    localparam logic [3:0] FN_TX_ACTIVITY_LED_N = 4'h0;
    localparam logic [3:0] FN_RX_ACTIVITY_LED_N = 4'h1;
    localparam logic [3:0] FN_TX_DRIVER_ENABLE = 4'h2;
    localparam logic [3:0] FN_POWER_ENABLE_N = 4'h3;
    localparam logic [3:0] FN_SLEEP = 4'h4;
    localparam logic [3:0] FN_IO_IN = 4'h5;
    localparam logic [3:0] FN_DRIVE_0 = 4'h6;
    localparam logic [3:0] FN_DRIVE_1 = 4'h7;

    // Factory functions, pin 4 down to pin 0
    localparam logic [4:0][3:0] AUX_DEFAULT = {FN_SLEEP, FN_POWER_ENABLE_N, FN_TX_DRIVER_ENABLE, FN_RX_ACTIVITY_LED_N, FN_TX_ACTIVITY_LED_N};

    // Pin positions
    localparam int PIN_POWER_ENABLE_N = 3;
    localparam int PIN_OUT_ONLY = 4;

    // Reset values
    localparam logic TXD_RST = 1'b1;
    localparam logic HS_N_RST = 1'b1;
    localparam logic [4:0] AUX_OE_N_RST = 5'h1F;
    localparam logic [4:0] AUX_O_RST = 5'h1F;
    localparam logic [4:0] AUX_PULL_RST = 5'h00;

    // Ring-indicator wake detector states
    typedef enum logic [1:0] {WK_IDLE, WK_COUNT, WK_HOLD} wake_state_e;
endpackage
`default_nettype wire

// file: core/ri_wake_detect.sv
// Ring-indicator remote wake detector: a long low pulse requests resume.
// Assumes ring_indicator_n is synchronous to clk_sys.
`default_nettype none
module ri_wake_detect #(
    parameter int PULSE_CYC = uart_pin_pkg::RI_PULSE_CYC // Low time in cycles
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic wake_en, // Remote wake enabled in config
    input wire logic usb_suspend, // USB link suspended
    input wire logic ring_indicator_n, // Ring indicator, active low
    output logic resume_req_r // One-cycle resume request
);
    import uart_pin_pkg::*;

    wake_state_e state_r, state_nxt;
    logic [RI_CNT_W-1:0] cnt_r, cnt_nxt;
    logic resume_nxt;
    logic armed;

    // Pulse length measurement
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        resume_nxt = 1'b0;
        armed = wake_en && usb_suspend && !ring_indicator_n;
        case (state_r)
            WK_IDLE: begin
                if (armed) begin
                    state_nxt = WK_COUNT;
                    cnt_nxt = RI_CNT_W'(1);
                end
            end
            WK_COUNT: begin
                if (!armed) begin
                    state_nxt = WK_IDLE;
                end else if (cnt_r == RI_CNT_W'(PULSE_CYC - 1)) begin
                    state_nxt = WK_HOLD;
                    resume_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + RI_CNT_W'(1);
                end
            end
            WK_HOLD: begin
                if (ring_indicator_n) begin
                    state_nxt = WK_IDLE;
                end
            end
            default: state_nxt = WK_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= WK_IDLE;
            cnt_r <= '0;
            resume_req_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            resume_req_r <= resume_nxt;
        end
    end

    // Resume only after a full-length low pulse while suspended and enabled
    property p_wake_resume;
        @(posedge clk_sys) disable iff (srst)
        $rose(resume_req_r) |-> $past(cnt_r) == RI_CNT_W'(PULSE_CYC - 1)
            && $past(usb_suspend) && $past(wake_en) && !$past(ring_indicator_n);
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("resume without full RI pulse");
endmodule
`default_nettype wire

// file: tb/uart_peer.sv
// Serial peer model: echoes data, answers handshakes, rings on request.
// Assumes it shares clk_sys with the bridge and moves lines just after rising edges.
`default_nettype none
module uart_peer (
    input wire logic clk_sys, // System clock
    input wire logic txd, // Data from the bridge
    input wire logic dtr_n, // Terminal ready from the bridge
    input wire logic rts_n, // Request to send from the bridge
    input wire logic ring_go, // Start a ring pulse
    input wire logic [7:0] ring_len, // Ring pulse length in cycles
    input wire logic test_req, // Probe test mode when high
    output logic rxd, // Data to the bridge
    output logic cts_n, // Clear to send
    output logic dsr_n, // Data set ready
    output logic carrier_detect_n, // Carrier detect
    output logic ring_indicator_n, // Ring indicator
    output logic test_sel // Factory test select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ring_cnt = 8'h00;
    logic [3:0] lfsr = 4'h9;
    // Test select grounded except during the test-mode probe
    assign test_sel = test_req;
    // Lines idle high before the first edge
    initial begin
        rxd = 1'b1;
        cts_n = 1'b1;
        dsr_n = 1'b1;
        carrier_detect_n = 1'b1;
        ring_indicator_n = 1'b1;
    end
    // Echo, follow handshakes, carrier wanders, ring counts down
    always @(posedge clk_sys) begin
        lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
        rxd <= txd;
        cts_n <= rts_n;
        dsr_n <= dtr_n;
        carrier_detect_n <= lfsr[0];
        if (ring_go) begin
            ring_cnt <= ring_len;
        end else if (ring_cnt != 8'h00) begin
            ring_cnt <= ring_cnt - 8'h01;
        end
        ring_indicator_n <= !(ring_go || ring_cnt > 8'h01);
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: random pins and config against a cycle model of the block.
// Assumes the design package, the design and the serial peer model compile first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pin_pkg::*;
    localparam int N = 8;
    logic clk_sys = 1'b0;
    logic srst = 1'b1, ce = 1'b1, ext_clear_n = 1'b1, osc_in_present = 1'b0, cfg_loaded = 1'b0;
    logic pull_low_in_suspend = 1'b0, remote_wake_en = 1'b0, usb_suspend = 1'b0, wen = 1'b0;
    logic tx_active = 1'b0, rx_active = 1'b0, tx_busy = 1'b0, txd_core = 1'b1;
    logic dtr_core_n = 1'b1, rts_core_n = 1'b1, ring_go = 1'b0, wake_mode = 1'b0, test_req = 1'b0;
    logic [7:0] ring_len = 8'h00;
    logic [AUX_N-1:0][AUX_FN_W-1:0] aux_fn_cfg = '0;
    logic [AUX_N-1:0] aux_ext = 5'h00, eo, eoe, epull;
    logic rxd, cts_n, dsr_n, carrier_detect_n, ring_indicator_n, test_sel;
    logic txd_r, dtr_n_r, rts_n_r, rxd_r, cts_n_r, dsr_n_r, carrier_detect_n_r;
    logic ring_indicator_n_r, resume_req_r, test_mode_r, clk_sel_ext_r, armed = 1'b1;
    logic [AUX_N-1:0] aux_pin_o_r, aux_pin_oe_n_r, aux_pin_in_r, aux_pull_dn_r;
    logic [30:0] exp_v;
    logic [7:0] tbl;
    logic [3:0] f;
    logic [31:0] seed = 32'h0000005C, r1;
    logic chk_on = 1'b0, wk;
    int cnt = 0, cyc = 0, n_errors = 0, n_compared = 0;
    // Aux wire level: own drive where enabled, outside level otherwise
    wire logic [AUX_N-1:0] aux_pin_i = (aux_pin_o_r & ~aux_pin_oe_n_r)
        | (aux_ext & aux_pin_oe_n_r);
    wire logic [30:0] got = {txd_r, dtr_n_r, rts_n_r, rxd_r, cts_n_r, dsr_n_r, carrier_detect_n_r,
        ring_indicator_n_r, aux_pin_o_r, aux_pin_oe_n_r, aux_pin_in_r, aux_pull_dn_r,
        resume_req_r, test_mode_r, clk_sel_ext_r};

    usb_uart_pin_control #(.RI_PULSE_CYC(N)) uut (.clk_sys, .srst, .ce, .ext_clear_n, .test_sel,
        .osc_in_present, .cfg_loaded, .aux_fn_cfg, .pull_low_in_suspend, .remote_wake_en,
        .usb_suspend, .tx_active, .rx_active, .tx_busy, .txd_core, .dtr_core_n, .rts_core_n,
        .rxd, .cts_n, .dsr_n, .carrier_detect_n, .ring_indicator_n, .aux_pin_i, .txd_r,
        .dtr_n_r, .rts_n_r, .rxd_r, .cts_n_r, .dsr_n_r, .carrier_detect_n_r, .ring_indicator_n_r,
        .aux_pin_o_r, .aux_pin_oe_n_r, .aux_pin_in_r, .aux_pull_dn_r, .resume_req_r,
        .test_mode_r, .clk_sel_ext_r);
    uart_peer peer (.clk_sys, .txd(txd_r), .dtr_n(dtr_n_r), .rts_n(rts_n_r), .ring_go,
        .ring_len, .test_req, .rxd, .cts_n, .dsr_n, .carrier_detect_n, .ring_indicator_n,
        .test_sel);

    always #20 clk_sys = !clk_sys;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Fresh random inputs after each edge; wake phase pins suspend and enable
    always @(posedge clk_sys) begin
        seed = xs(seed);
        r1 = xs(seed);
        cyc++;
        srst <= !wake_mode && (cyc < 2 || seed[31:24] == 8'h00);
        ext_clear_n <= wake_mode || seed[23:18] != 6'h00;
        ce <= wake_mode || seed[2:0] != 3'h0;
        usb_suspend <= wake_mode || seed[3];
        remote_wake_en <= wake_mode ? wen : seed[4];
        {osc_in_present, cfg_loaded, pull_low_in_suspend} <= seed[7:5];
        {tx_active, rx_active, tx_busy, txd_core, dtr_core_n, rts_core_n} <= seed[13:8];
        aux_ext <= r1[24:20];
        for (int i = 0; i < AUX_N; i++) begin
            aux_fn_cfg[i] <= r1[4*i +: 4];
        end
    end

    // Cycle model: outputs due after the coming edge
    always @(negedge clk_sys) begin
        chk_on = 1'b1;
        if (srst || !ext_clear_n) begin
            exp_v = {8'hFF, 15'h7FFF, 5'h00, 3'h0};
            cnt = 0;
            armed = 1'b1;
        end else if (ce) begin
            tbl = {1'b1, 2'h0, !usb_suspend, usb_suspend, tx_busy, !rx_active, !tx_active};
            for (int i = 0; i < AUX_N; i++) begin
                f = cfg_loaded ? aux_fn_cfg[i] : AUX_DEFAULT[i];
                if (i == PIN_OUT_ONLY && (f == FN_IO_IN || f[3])) begin
                    f = FN_SLEEP;
                end
                eoe[i] = f == FN_IO_IN || f[3];
                eo[i] = !eoe[i] && tbl[f[2:0]];
                epull[i] = eoe[i] && usb_suspend && pull_low_in_suspend;
            end
            if (remote_wake_en && usb_suspend && !ring_indicator_n) begin
                cnt++;
            end else begin
                cnt = 0;
            end
            if (ring_indicator_n) begin
                armed = 1'b1;
            end
            wk = armed && cnt == N;
            if (wk) begin
                armed = 1'b0;
            end
            exp_v = {txd_core, dtr_core_n, rts_core_n, rxd, cts_n, dsr_n, carrier_detect_n,
                ring_indicator_n, eo, eoe, aux_pin_i, epull, wk, test_sel, osc_in_present};
        end
    end

    // Compare every output just after each edge
    always @(posedge clk_sys) begin
        #1;
        if (chk_on) begin
            chk(20'(got[30:23]), 20'(exp_v[30:23]));
            chk(got[22:3], exp_v[22:3]);
            chk(20'(got[2]), 20'(exp_v[2]));
            chk(20'(got[1:0]), 20'(exp_v[1:0]));
        end
    end

    // Random phase, then ring pulses: short, exact, long, wake disabled
    initial begin
        repeat (600) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            wake_mode <= 1'b1;
            wen <= k != 3;
            repeat (3) @(posedge clk_sys);
            ring_len <= k == 0 ? 8'h07 : k == 1 ? 8'h08 : 8'h0C;
            ring_go <= 1'b1;
            @(posedge clk_sys);
            ring_go <= 1'b0;
            repeat (20) @(posedge clk_sys);
            wake_mode <= 1'b0;
        end
        test_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        test_req <= 1'b0;
        repeat (200) @(posedge clk_sys);
        wrap_up();
    end

    // Hang guard
    initial begin
        #4000000;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
